// file: core/kfs_defines.svh
// register offsets, field positions and reset values for the fec/backplane_1g_status bank
`ifndef KFS_DEFINES_SVH
`define KFS_DEFINES_SVH
`define KFS_DEV_ADDR 5'h01
`define KFS_OFF_TRAIN_LOCAL_STATUS 16'h009B
`define KFS_OFF_BACKPLANE_1G_STATUS 16'h00A1
`define KFS_OFF_FEC_CAPABILITY 16'h00AA
`define KFS_OFF_FEC_CONTROL 16'h00AB
`define KFS_OFF_FEC_CORRECTED_LOW 16'h00AC
`define KFS_OFF_FEC_CORRECTED_HIGH 16'h00AD
`define KFS_RST_BACKPLANE_1G_STATUS 16'h3000
`define KFS_RST_FEC_CAPABILITY 16'h0003
`define KFS_RST_FEC_CONTROL 16'h0000
`define KFS_BIT_RX_TRAINED 15
`define KFS_BIT_POST_TAP 4
`define KFS_MSB_MAIN_TAP 3
`define KFS_LSB_MAIN_TAP 2
`define KFS_MSB_PRE_TAP 1
`define KFS_LSB_PRE_TAP 0
`define KFS_BIT_TX_FAULT_CAP 13
`define KFS_BIT_RX_FAULT_CAP 12
`define KFS_BIT_TX_FAULT 11
`define KFS_BIT_RX_FAULT 10
`define KFS_BIT_SIGNAL 0
`define KFS_BIT_CORR_EN 0
`define KFS_BIT_ERRFLAG_EN 1
`endif

// file: core/kfs_pkg.sv
// types shared by the fec/backplane_1g_status bank
package kfs_pkg;
  // two-bit coefficient status codes
  typedef enum logic [1:0] {
    KFS_TAP_NOT_UPDATED = 2'h0,
    KFS_TAP_UPDATED = 2'h1,
    KFS_TAP_MINIMUM = 2'h2,
    KFS_TAP_MAXIMUM = 2'h3
  } kfs_tap_stat_t;
  // live status from training engine and 1g paths
  typedef struct packed {
    logic rx_trained;
    kfs_tap_stat_t post_tap;
    kfs_tap_stat_t main_tap;
    kfs_tap_stat_t pre_tap;
    logic tx_fault;
    logic rx_fault;
    logic signal;
  } kfs_status_t;
  // control toward the fec decoder
  typedef struct packed {
    logic correction_enable;
    logic error_flag_enable;
  } kfs_ctrl_t;
endpackage

// file: core/kfs_sync2.sv
// two-stage synchroniser for a bundle of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module kfs_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // state: first stage is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } kfs_sync_state_t;
  kfs_sync_state_t state_reg;
  kfs_sync_state_t state_next;
  // next-state
  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end
  // register stages
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign sync_out = state_reg.stable;
endmodule
`default_nettype wire

// file: core/kfs_regs.sv
// management register bank for kr training status, 1g status, fec control and counter
`timescale 1ns/1ps
`default_nettype none
`include "kfs_defines.svh"
module kfs_regs #(
  parameter int CNT_WIDTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // management access, already decoded to device address and register offset
  input wire logic [15:0] mgmt_addr_in,
  input wire logic mgmt_rd_in,
  input wire logic mgmt_wr_in,
  input wire logic [15:0] mgmt_wdata_in,
  output logic [15:0] mgmt_rdata_out,
  output logic mgmt_rvalid_out,
  // status from training engine and 1g paths (asynchronous)
  input wire kfs_pkg::kfs_status_t status_in,
  // corrected-block event from fec decoder (same clock)
  input wire logic corrected_block_in,
  // control toward the fec decoder
  output kfs_pkg::kfs_ctrl_t ctrl_out
);
  // ****************************************************
  // input synchronisation
  // ****************************************************
  kfs_pkg::kfs_status_t status_sync;
  kfs_sync2 #(
    .WIDTH($bits(kfs_pkg::kfs_status_t))
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(status_in),
    .sync_out(status_sync)
  );

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic tx_fault_latched;
    logic rx_fault_latched;
    logic correction_enable;
    logic error_flag_enable;
    logic [CNT_WIDTH-1:0] corrected_block_count;
    logic [15:0] high_snapshot;
    logic snapshot_valid;
    logic [15:0] rdata;
    logic rvalid;
  } kfs_state_t;
  kfs_state_t state_reg;
  kfs_state_t state_next;

  // ****************************************************
  // read decode
  // ****************************************************
  logic rd_status;
  logic rd_low;
  logic rd_high;
  logic [15:0] train_word;
  logic [15:0] bp_word;
  logic [15:0] rd_word;

  // live training status word
  always_comb begin
    train_word = 16'h0000;
    train_word[`KFS_BIT_RX_TRAINED] = status_sync.rx_trained;
    train_word[`KFS_MSB_MAIN_TAP:`KFS_LSB_MAIN_TAP] = status_sync.main_tap;
    train_word[`KFS_MSB_PRE_TAP:`KFS_LSB_PRE_TAP] = status_sync.pre_tap;
    // only one bit position exists; report the upper bit of the code
    train_word[`KFS_BIT_POST_TAP] = status_sync.post_tap[1];
  end

  // 1g backplane status word
  always_comb begin
    bp_word = 16'h0000;
    bp_word[`KFS_BIT_TX_FAULT_CAP] = 1'b1;
    bp_word[`KFS_BIT_RX_FAULT_CAP] = 1'b1;
    bp_word[`KFS_BIT_TX_FAULT] = state_reg.tx_fault_latched;
    bp_word[`KFS_BIT_RX_FAULT] = state_reg.rx_fault_latched;
    bp_word[`KFS_BIT_SIGNAL] = status_sync.signal;
  end

  // address decode and read mux
  always_comb begin
    rd_status = 1'b0;
    rd_low = 1'b0;
    rd_high = 1'b0;
    rd_word = 16'h0000;
    if (mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS) begin
      rd_word = train_word;
    end else if (mgmt_addr_in == `KFS_OFF_BACKPLANE_1G_STATUS) begin
      rd_word = bp_word;
      rd_status = mgmt_rd_in;
    end else if (mgmt_addr_in == `KFS_OFF_FEC_CAPABILITY) begin
      rd_word = `KFS_RST_FEC_CAPABILITY;
    end else if (mgmt_addr_in == `KFS_OFF_FEC_CONTROL) begin
      rd_word = 16'h0000;
      rd_word[`KFS_BIT_CORR_EN] = state_reg.correction_enable;
      rd_word[`KFS_BIT_ERRFLAG_EN] = state_reg.error_flag_enable;
    end else if (mgmt_addr_in == `KFS_OFF_FEC_CORRECTED_LOW) begin
      rd_word = state_reg.corrected_block_count[15:0];
      rd_low = mgmt_rd_in;
    end else if (mgmt_addr_in == `KFS_OFF_FEC_CORRECTED_HIGH) begin
      // after a low read the snapshot answers; otherwise live upper half
      rd_word = state_reg.snapshot_valid ? state_reg.high_snapshot
                                         : state_reg.corrected_block_count[31:16];
      rd_high = mgmt_rd_in;
    end else begin
      rd_word = 16'h0000;
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = mgmt_rd_in;
    state_next.rdata = mgmt_rd_in ? rd_word : state_reg.rdata;
    // read clears the latch, but a present fault sets it again (set wins)
    if (rd_status) begin
      state_next.tx_fault_latched = 1'b0;
      state_next.rx_fault_latched = 1'b0;
    end
    if (status_sync.tx_fault) begin
      state_next.tx_fault_latched = 1'b1;
    end
    if (status_sync.rx_fault) begin
      state_next.rx_fault_latched = 1'b1;
    end
    // control writes; reserved bits are dropped
    if (mgmt_wr_in && (mgmt_addr_in == `KFS_OFF_FEC_CONTROL)) begin
      state_next.correction_enable = mgmt_wdata_in[`KFS_BIT_CORR_EN];
      state_next.error_flag_enable = mgmt_wdata_in[`KFS_BIT_ERRFLAG_EN];
    end
    // low read clears the low half and parks the high half in the snapshot
    if (rd_low) begin
      state_next.high_snapshot = state_reg.corrected_block_count[31:16];
      state_next.snapshot_valid = 1'b1;
      state_next.corrected_block_count[15:0] = 16'h0000;
    end
    if (rd_high) begin
      state_next.snapshot_valid = 1'b0;
      state_next.high_snapshot = 16'h0000;
      state_next.corrected_block_count[31:16] = 16'h0000;
    end
    // count resumes after the clear; an event in a read cycle lands in the fresh value
    if (corrected_block_in) begin
      state_next.corrected_block_count =
        state_next.corrected_block_count + CNT_WIDTH'(1);
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign mgmt_rdata_out = state_reg.rdata;
  assign mgmt_rvalid_out = state_reg.rvalid;
  // one driver for the whole packed struct; split member assigns would clash
  assign ctrl_out = {state_reg.correction_enable,
                     state_reg.error_flag_enable};

  // ****************************************************
  // assertions
  // ****************************************************
  // a seen transmit fault must be latched
  a_tx_fault_latch: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    status_sync.tx_fault |=> state_reg.tx_fault_latched)
    else $error("tx fault not latched");

  // a seen receive fault must be latched
  a_rx_fault_latch: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    status_sync.rx_fault |=> state_reg.rx_fault_latched)
    else $error("rx fault not latched");

  // transmit latch only drops through a status read
  a_fault_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_reg.tx_fault_latched && !rd_status |=> state_reg.tx_fault_latched)
    else $error("tx fault dropped without read");

  // receive latch only drops through a status read
  a_rx_fault_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_reg.rx_fault_latched && !rd_status |=> state_reg.rx_fault_latched)
    else $error("rx fault dropped without read");

  // read with the receive fault gone clears it
  a_fault_clear_read: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_status && !status_sync.rx_fault |=> !state_reg.rx_fault_latched)
    else $error("rx fault not cleared by read");

  // read with the transmit fault gone clears it
  a_tx_clear_read: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_status && !status_sync.tx_fault |=> !state_reg.tx_fault_latched)
    else $error("tx fault not cleared by read");

  // set wins over the read clear while the fault persists
  a_fault_relatch: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_status && status_sync.tx_fault |=> state_reg.tx_fault_latched)
    else $error("persistent tx fault lost on read");

  // both capability bits read one
  a_cap_reads_one: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_BACKPLANE_1G_STATUS
    |=> mgmt_rdata_out[13:12] == 2'h3)
    else $error("fault capability bits not one");

  // status register reserved bits stay zero
  a_bp_reserved: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_BACKPLANE_1G_STATUS
    |=> mgmt_rdata_out[15:14] == 2'h0 && mgmt_rdata_out[9:1] == 9'h000)
    else $error("status reserved bits nonzero");

  // signal detect reads the level seen at the read edge
  a_signal_bit: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_BACKPLANE_1G_STATUS
    |=> mgmt_rdata_out[0] == $past(status_sync.signal))
    else $error("signal detect bit wrong");

  // trained bit follows the synchronised level
  a_trained_bit: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS
    |=> mgmt_rdata_out[15] == $past(status_sync.rx_trained))
    else $error("trained bit wrong");

  // main tap code lands in its two bits
  a_main_tap: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS
    |=> mgmt_rdata_out[3:2] == $past(status_sync.main_tap))
    else $error("main tap field wrong");

  // pre tap code lands in its two bits
  a_pre_tap: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS
    |=> mgmt_rdata_out[1:0] == $past(status_sync.pre_tap))
    else $error("pre tap field wrong");

  // single post tap bit carries the upper code bit
  a_post_tap: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS
    |=> mgmt_rdata_out[4] == $past(status_sync.post_tap[1]))
    else $error("post tap bit wrong");

  // unused training status bits read zero
  a_train_reserved: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_TRAIN_LOCAL_STATUS
    |=> mgmt_rdata_out[14:5] == 10'h000)
    else $error("training reserved bits nonzero");

  // capability word is fixed
  a_ability_read: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_FEC_CAPABILITY
    |=> mgmt_rdata_out == 16'h0003)
    else $error("fec capability wrong");

  // control reserved bits never read back
  a_ctrl_reserved: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in && mgmt_addr_in == `KFS_OFF_FEC_CONTROL
    |=> mgmt_rdata_out[15:2] == 14'h0000)
    else $error("control reserved bits nonzero");

  // a control write takes effect on the next cycle
  a_ctrl_write: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_wr_in && mgmt_addr_in == `KFS_OFF_FEC_CONTROL
    |=> ctrl_out.correction_enable == $past(mgmt_wdata_in[0])
        && ctrl_out.error_flag_enable == $past(mgmt_wdata_in[1]))
    else $error("control write not applied");

  // control holds unless the control register is written
  a_ctrl_hold: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !(mgmt_wr_in && mgmt_addr_in == `KFS_OFF_FEC_CONTROL) |=> $stable(ctrl_out))
    else $error("control changed without write");

  // every read is answered one cycle later
  a_rvalid_pulse: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    mgmt_rd_in |=> mgmt_rvalid_out)
    else $error("read not answered");

  // no answer without a read
  a_rvalid_idle: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !mgmt_rd_in |=> !mgmt_rvalid_out)
    else $error("answer without read");

  // low read clears the low half
  a_low_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_low && !corrected_block_in |=> state_reg.corrected_block_count[15:0] == 16'h0000)
    else $error("low half not cleared on read");

  // high read clears the high half and drops the snapshot
  a_high_clear: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_high && !rd_low |=> state_reg.corrected_block_count[31:16] == 16'h0000
      && !state_reg.snapshot_valid)
    else $error("high half not cleared on read");

  // low read parks the high half
  a_snapshot_take: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_low |=> state_reg.snapshot_valid
      && state_reg.high_snapshot == $past(state_reg.corrected_block_count[31:16]))
    else $error("high half snapshot wrong");

  // one count per event outside read cycles
  a_count_step: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    corrected_block_in && !mgmt_rd_in
    |=> state_reg.corrected_block_count == $past(state_reg.corrected_block_count) + 1)
    else $error("counter did not advance");
endmodule
`default_nettype wire

// file: tb/kfs_mgmt_model.sv
// management station model driving the register port of the status bank
`timescale 1ns/1ps
`default_nettype none
`include "kfs_defines.svh"
module kfs_mgmt_model (
  // clock
  input wire logic clk_in,
  // request side
  output logic [15:0] addr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [15:0] wdata_out,
  // answer side
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in
);
  // idle lines start inverted so a stale value is never mistaken for a request
  initial begin
    addr_out = 16'hFFFF;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 16'hFFFF;
  end
  // one write strobe, then the released bus shows the inverse
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // one read strobe, answer awaited under a small bound
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_in === 1'b1) begin
        d = rdata_in;
        ok = 1'b1;
      end else begin
        @(negedge clk_in);
      end
    end
  endtask
  // low half first, so the high half comes from the same snapshot
  task automatic rd_count(output logic [31:0] c, output logic ok);
    logic ok_lo;
    rd(`KFS_OFF_FEC_CORRECTED_LOW, c[15:0], ok_lo);
    rd(`KFS_OFF_FEC_CORRECTED_HIGH, c[31:16], ok);
    ok = ok & ok_lo;
  endtask
endmodule
`default_nettype wire

// file: tb/kfs_regs_tb.sv
// self-checking bench for the fec/backplane_1g_status register bank
`timescale 1ns/1ps
`default_nettype none
`include "kfs_defines.svh"
module kfs_regs_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] m_addr;
  logic m_rd;
  logic m_wr;
  logic [15:0] m_wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic blk = 1'b0;
  kfs_pkg::kfs_status_t st = '0;
  kfs_pkg::kfs_ctrl_t ctrl;
  int num_errors = 0;
  int num_checks = 0;
  // 100 mhz clock
  always #5 clk_in = ~clk_in;
  kfs_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .mgmt_addr_in(m_addr),
    .mgmt_rd_in(m_rd), .mgmt_wr_in(m_wr), .mgmt_wdata_in(m_wdata),
    .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rvalid), .status_in(st),
    .corrected_block_in(blk), .ctrl_out(ctrl));
  kfs_mgmt_model m (.clk_in(clk_in), .addr_out(m_addr), .rd_out(m_rd), .wr_out(m_wr),
    .wdata_out(m_wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  // verdict and end of run
  task conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // single compare for every value
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // a lost answer ends the run at once
  task guard(input logic ok);
    if (ok !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    m.rd(a, d, ok);
    guard(ok);
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, d});
  endtask
  // write control, let the update land, then look at the decoder side
  task wchk(input logic [15:0] d, input logic [1:0] e);
    m.wr(`KFS_OFF_FEC_CONTROL, d);
    @(negedge clk_in);
    chk("ctrl", {30'h0, e}, {30'h0, ctrl});
  endtask
  // reset values, unmapped offset reads zero
  task t_reset;
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3000);
    rchk(`KFS_OFF_FEC_CAPABILITY, 16'h0003);
    rchk(`KFS_OFF_FEC_CONTROL, 16'h0000);
    rchk(`KFS_OFF_FEC_CORRECTED_LOW, 16'h0000);
    rchk(`KFS_OFF_FEC_CORRECTED_HIGH, 16'h0000);
    rchk(16'h00A2, 16'h0000);
  endtask
  // every tap code, pre tap runs opposite so fields cannot be swapped unseen
  task t_train;
    for (int c = 0; c < 4; c++) begin
      st.rx_trained = c[0];
      st.post_tap = kfs_pkg::kfs_tap_stat_t'(c);
      st.main_tap = kfs_pkg::kfs_tap_stat_t'(c);
      st.pre_tap = kfs_pkg::kfs_tap_stat_t'(3 - c);
      repeat (3) @(negedge clk_in);
      rchk(`KFS_OFF_TRAIN_LOCAL_STATUS, {c[0], 10'h000, c[1], c[1:0], 2'(3 - c)});
    end
  endtask
  // short and persistent faults, signal level
  task t_fault;
    st.tx_fault = 1'b1;
    st.signal = 1'b1;
    repeat (2) @(negedge clk_in);
    st.tx_fault = 1'b0;
    repeat (4) @(negedge clk_in);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3801);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3001);
    st.rx_fault = 1'b1;
    repeat (4) @(negedge clk_in);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3401);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3401);
    st.rx_fault = 1'b0;
    st.signal = 1'b0;
    repeat (4) @(negedge clk_in);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3400);
    rchk(`KFS_OFF_BACKPLANE_1G_STATUS, 16'h3000);
  endtask
  // control bits apart and together, reserved bits and read-only place
  task t_ctrl;
    wchk(16'hFFFF, 2'h3);
    rchk(`KFS_OFF_FEC_CONTROL, 16'h0003);
    wchk(16'h0001, 2'h2);
    wchk(16'h0002, 2'h1);
    m.wr(`KFS_OFF_FEC_CAPABILITY, 16'h0000);
    rchk(`KFS_OFF_FEC_CAPABILITY, 16'h0003);
    wchk(16'h0000, 2'h0);
  endtask
  // count past the half boundary, then clear on read and resume
  task t_count;
    logic [31:0] c;
    logic ok;
    blk = 1'b1;
    repeat (65538) @(negedge clk_in);
    blk = 1'b0;
    @(negedge clk_in);
    m.rd_count(c, ok);
    guard(ok);
    chk("count", 32'h0001_0002, c);
    blk = 1'b1;
    repeat (3) @(negedge clk_in);
    blk = 1'b0;
    @(negedge clk_in);
    m.rd_count(c, ok);
    guard(ok);
    chk("count", 32'h0000_0003, c);
  endtask
  // main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_train();
    t_fault();
    t_ctrl();
    t_count();
    conclude();
  end
  // bound on the whole run
  initial begin
    repeat (100000) @(negedge clk_in);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
